// ---- rtl/bfx_pkg.sv ----
// constants, types and decode shared by the bit and flag execution block
// assumes a single core clock and an external working-register file
package bfx_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_OPERAND = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ISSUE   = 8'h08;
  localparam logic [7:0] OFS_RESULT  = 8'h0C;

  // ****************************************
  // status and result register field positions and register reset values
  // ****************************************
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam int RES_BUSY = 8;
  localparam logic [7:0]  STAT_RST   = 8'h00;
  localparam logic [7:0]  RESULT_RST = 8'h00;
  localparam logic [31:0] OPND_RST   = 32'h0000_0000;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00, OP_BIT_TO_TFLAG = 5'h01, OP_TFLAG_TO_BIT = 5'h02,
    OP_IO_BIT_SET   = 5'h03, OP_IO_BIT_CLEAR = 5'h04, OP_ROT_LEFT     = 5'h05,
    OP_ROT_RIGHT    = 5'h06, OP_HC_SET       = 5'h07, OP_HC_CLEAR     = 5'h08,
    OP_OV_SET       = 5'h09, OP_OV_CLEAR     = 5'h0A, OP_SF_SET       = 5'h0B,
    OP_SF_CLEAR     = 5'h0C, OP_IND_LOAD     = 5'h0D, OP_IND_STORE    = 5'h0E,
    OP_PM_LOAD      = 5'h0F, OP_MOVE         = 5'h10, OP_LOAD_IMM     = 5'h11,
    OP_PORT_IN      = 5'h12, OP_PORT_OUT     = 5'h13
  } bfx_op_t;

  typedef enum logic [1:0] {
    SP_IO   = 2'h0,
    SP_DATA = 2'h1,
    SP_PROG = 2'h2
  } bfx_space_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] zptr;
    logic [7:0]  src;
    logic [7:0]  rd;
  } bfx_opnd_t;

  typedef struct packed {
    logic [9:0] rsvd_hi;
    logic [5:0] io_addr;
    logic [4:0] rsvd_mid;
    logic [2:0] bit_idx;
    logic [2:0] rsvd_lo;
    logic [4:0] op;
  } bfx_issue_t;

  typedef struct packed {
    logic        re;
    logic        we;
    bfx_space_t  space;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bfx_ext_t;

  // cycles taken by an operation; unknown codes run as a one-cycle no-op
  function automatic logic [1:0] bfx_cycles(input logic [4:0] op);
    unique case (op)
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_IND_LOAD, OP_IND_STORE: bfx_cycles = CYC_TWO;
      OP_PM_LOAD: bfx_cycles = CYC_THREE;
      default:    bfx_cycles = CYC_ONE;
    endcase
  endfunction

endpackage

// ---- rtl/bfx_seq.sv ----
// one-hot cycle sequencer for a single in-flight operation
// assumes start is only raised while idle
module bfx_seq
  import bfx_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       start,
  input  wire logic [1:0] len,
  // state
  output logic            in_c1,
  output logic            in_c2,
  output logic            last,
  output logic            busy
);

  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0001,
    SQ_C1   = 4'b0010,
    SQ_C2   = 4'b0100,
    SQ_C3   = 4'b1000
  } bfx_sq_t;

  bfx_sq_t    state_q, state_d;
  logic [1:0] len_q;

  // length is latched so a later issue field cannot stretch a running op
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_q <= CYC_ONE;
    end else if (start) begin
      len_q <= len;
    end
  end

  // next state: advance one step per clock until the last cycle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SQ_IDLE: if (start) state_d = SQ_C1;
      SQ_C1:   state_d = (len_q == CYC_ONE) ? SQ_IDLE : SQ_C2;
      SQ_C2:   state_d = (len_q == CYC_TWO) ? SQ_IDLE : SQ_C3;
      SQ_C3:   state_d = SQ_IDLE;
      default: state_d = SQ_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // decoded views of the state
  assign in_c1 = (state_q == SQ_C1);
  assign in_c2 = (state_q == SQ_C2);
  assign busy  = (state_q != SQ_IDLE);
  assign last  = (in_c1 && len_q == CYC_ONE) || (in_c2 && len_q == CYC_TWO) || (state_q == SQ_C3);

endmodule

// ---- rtl/bfx_alu.sv ----
// combinational result and status update for register and flag operations
// assumes transfer operations are resolved by the caller
module bfx_alu
  import bfx_pkg::*;
(
  // operation
  input  wire logic [4:0] op,
  input  wire logic [2:0] bit_idx,
  // operands
  input  wire logic [7:0] rd,
  input  wire logic [7:0] src,
  input  wire logic [7:0] stat,
  // results
  output logic [7:0]      res,
  output logic [7:0]      stat_new
);

  logic [7:0] r;
  logic       c;

  // every path starts from the old values so untouched flags hold
  always_comb begin
    r = rd;
    c = stat[FLG_C];
    res = rd;
    stat_new = stat;
    unique case (op)
      OP_BIT_TO_TFLAG: stat_new[FLG_T] = rd[bit_idx];
      OP_TFLAG_TO_BIT: res[bit_idx] = stat[FLG_T];
      OP_ROT_LEFT, OP_ROT_RIGHT: begin
        if (op == OP_ROT_LEFT) begin
          r = {rd[6:0], stat[FLG_C]};
          c = rd[7];
        end else begin
          r = {stat[FLG_C], rd[7:1]};
          c = rd[0];
        end
        res = r;
        stat_new[FLG_C] = c;
        stat_new[FLG_Z] = (r == 8'h00);
        stat_new[FLG_N] = r[7];
        stat_new[FLG_V] = r[7] ^ c;
      end
      OP_HC_SET:   stat_new[FLG_H] = 1'b1;
      OP_HC_CLEAR: stat_new[FLG_H] = 1'b0;
      OP_OV_SET:   stat_new[FLG_V] = 1'b1;
      OP_OV_CLEAR: stat_new[FLG_V] = 1'b0;
      OP_SF_SET:   stat_new[FLG_S] = 1'b1;
      OP_SF_CLEAR: stat_new[FLG_S] = 1'b0;
      OP_MOVE, OP_LOAD_IMM: res = src;
      default: res = rd;
    endcase
  end

endmodule

// ---- rtl/bfx_exec.sv ----
// bit and flag execution unit with an AHB-Lite register port
// assumes the working register file and I/O, data and program spaces sit outside
// and answer ext_rdata combinationally while a read strobe is up
//
// Notes on behaviour
// - copying a register bit to the T flag takes one cycle and touches only T.
// - copying T into a register bit takes one cycle and leaves every flag alone.
// - setting an I/O register bit forces it to one over two cycles with no flag change.
// - clearing an I/O register bit forces it to zero over two cycles with no flag change.
// - rotate left moves carry into bit 0 and bit 7 into carry, updating Z C N V in one cycle.
// - rotate right moves carry into bit 7 and bit 0 into carry, updating Z C N V in one cycle.
// - half-carry set and clear take one cycle and change only that flag.
// - overflow set and clear take one cycle and change only that flag.
// - signed flag set and clear take one cycle and change only that flag.
module bfx_exec
  import bfx_pkg::*;
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // external spaces
  output bfx_pkg::bfx_ext_t      ext_req,
  input  wire logic [7:0]        ext_rdata
);

  import bfx_pkg::*;

  // ****************************************
  // bus slave
  // ****************************************
  logic       dph_we_q;
  logic [7:0] dph_addr_q;
  logic [31:0] hrdata_q;
  bfx_opnd_t  opnd_q;
  logic [7:0] stat_q;
  logic [7:0] result_q;
  bfx_op_t    op_q;
  logic [2:0] bit_q;
  logic [5:0] io_q;
  logic [7:0] io_cap_q;
  logic       busy;
  logic       in_c1;
  logic       in_c2;
  logic       exec_last;
  logic       addr_ok;
  logic       issue_fire;
  bfx_issue_t iss;
  logic [7:0] alu_res;
  logic [7:0] alu_stat;

  assign addr_ok = hsel && htrans[1] && hready;
  assign iss = bfx_issue_t'(hwdata);
  // issue writes during a running op are dropped; software polls busy
  assign issue_fire = dph_we_q && (dph_addr_q == OFS_ISSUE) && !busy;

  // address phase capture; hsize is ignored, only whole words are used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_we_q   <= 1'b0;
      dph_addr_q <= 8'h00;
    end else begin
      dph_we_q   <= addr_ok && hwrite;
      dph_addr_q <= haddr[7:0];
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        OFS_OPERAND: hrdata_q <= opnd_q;
        OFS_STATUS:  hrdata_q <= {24'h00_0000, stat_q};
        OFS_RESULT:  hrdata_q <= {23'h00_0000, busy, result_q};
        default:     hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // operand register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opnd_q <= OPND_RST;
    end else if (dph_we_q && dph_addr_q == OFS_OPERAND) begin
      opnd_q <= hwdata;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  // issue fields latched so the bus may move on while the op runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q  <= OP_NOP;
      bit_q <= 3'h0;
      io_q  <= 6'h00;
    end else if (issue_fire) begin
      op_q  <= bfx_op_t'(iss.op);
      bit_q <= iss.bit_idx;
      io_q  <= iss.io_addr;
    end
  end

  bfx_seq u_seq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (issue_fire),
    .len     (bfx_cycles(iss.op)),
    .in_c1   (in_c1),
    .in_c2   (in_c2),
    .last    (exec_last),
    .busy    (busy)
  );

  bfx_alu u_alu (
    .op       (op_q),
    .bit_idx  (bit_q),
    .rd       (opnd_q.rd),
    .src      (opnd_q.src),
    .stat     (stat_q),
    .res      (alu_res),
    .stat_new (alu_stat)
  );

  // ****************************************
  // external access
  // ****************************************
  // strobes are decoded from the latched op and the one-hot state only
  always_comb begin
    ext_req = '0;
    ext_req.space = SP_IO;
    ext_req.addr = {10'h000, io_q};
    unique case (op_q)
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
        ext_req.re = in_c1;
        ext_req.we = in_c2;
        ext_req.wdata = io_cap_q;
        ext_req.wdata[bit_q] = (op_q == OP_IO_BIT_SET);
      end
      OP_PORT_IN:  ext_req.re = in_c1;
      OP_PORT_OUT: begin
        ext_req.we = in_c1;
        ext_req.wdata = opnd_q.rd;
      end
      OP_IND_LOAD, OP_IND_STORE, OP_PM_LOAD: begin
        ext_req.space = (op_q == OP_PM_LOAD) ? SP_PROG : SP_DATA;
        ext_req.addr = opnd_q.zptr;
        ext_req.re = busy && (op_q != OP_IND_STORE);
        ext_req.we = in_c2 && (op_q == OP_IND_STORE);
        ext_req.wdata = opnd_q.rd;
      end
      default: ext_req.re = 1'b0;
    endcase
  end

  // i/o value caught in the first cycle of a bit set or clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_cap_q <= 8'h00;
    end else if (in_c1) begin
      io_cap_q <= ext_rdata;
    end
  end

  // ****************************************
  // result and status
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= RESULT_RST;
    end else if (exec_last) begin
      unique case (op_q)
        OP_PORT_IN, OP_IND_LOAD, OP_PM_LOAD: result_q <= ext_rdata;
        default: result_q <= alu_res;
      endcase
    end
  end

  // execution wins over a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= STAT_RST;
    end else if (exec_last) begin
      stat_q <= alu_stat;
    end else if (dph_we_q && dph_addr_q == OFS_STATUS) begin
      stat_q <= hwdata[7:0];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_tflag_store;
    @(posedge hclk) disable iff (!hresetn)
      issue_fire && iss.op == OP_BIT_TO_TFLAG |=> exec_last ##1
        (stat_q[FLG_T] == $past(opnd_q.rd[bit_q])) && ((stat_q ^ $past(stat_q)) & 8'hBF) == 8'h00;
  endproperty
  a_tflag_store: assert property (p_tflag_store) else $error("t flag store wrong");

  property p_tflag_load;
    @(posedge hclk) disable iff (!hresetn)
      exec_last && op_q == OP_TFLAG_TO_BIT |=>
        result_q[$past(bit_q)] == $past(stat_q[FLG_T]) && stat_q == $past(stat_q);
  endproperty
  a_tflag_load: assert property (p_tflag_load) else $error("t flag load wrong");

  property p_io_set;
    @(posedge hclk) disable iff (!hresetn)
      issue_fire && iss.op == OP_IO_BIT_SET |=> ext_req.re && !ext_req.we ##1
        ext_req.we && exec_last && ext_req.wdata[bit_q] ##1 !busy && stat_q == $past(stat_q, 2);
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");

  property p_io_clear;
    @(posedge hclk) disable iff (!hresetn)
      in_c2 && op_q == OP_IO_BIT_CLEAR |->
        ext_req.we && !ext_req.wdata[bit_q] && ext_req.wdata == ($past(ext_rdata) & ~(8'h01 << bit_q));
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong");

  // the write-back must carry every other bit exactly as read in the first cycle
  property p_io_set_keep;
    @(posedge hclk) disable iff (!hresetn)
      in_c2 && op_q == OP_IO_BIT_SET |->
        ext_req.wdata == ($past(ext_rdata) | (8'h01 << bit_q)) && ext_req.space == SP_IO;
  endproperty
  a_io_set_keep: assert property (p_io_set_keep) else $error("io bit set disturbed other bits");

  property p_rot_left;
    @(posedge hclk) disable iff (!hresetn)
      exec_last && op_q == OP_ROT_LEFT |=>
        result_q == {$past(opnd_q.rd[6:0]), $past(stat_q[FLG_C])} && stat_q[FLG_C] == $past(opnd_q.rd[7])
        && stat_q[FLG_Z] == (result_q == 8'h00) && stat_q[FLG_S] == $past(stat_q[FLG_S]);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

  property p_rot_right;
    @(posedge hclk) disable iff (!hresetn)
      exec_last && op_q == OP_ROT_RIGHT |=>
        result_q == {$past(stat_q[FLG_C]), $past(opnd_q.rd[7:1])} && stat_q[FLG_C] == $past(opnd_q.rd[0])
        && stat_q[FLG_V] == (result_q[7] ^ stat_q[FLG_C]);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

  property p_half_carry;
    @(posedge hclk) disable iff (!hresetn)
      issue_fire && (iss.op == OP_HC_SET || iss.op == OP_HC_CLEAR) |=> exec_last ##1
        stat_q[FLG_H] == ($past(op_q) == OP_HC_SET) && ((stat_q ^ $past(stat_q)) & 8'hDF) == 8'h00;
  endproperty
  a_half_carry: assert property (p_half_carry) else $error("half carry op wrong");

  property p_overflow;
    @(posedge hclk) disable iff (!hresetn)
      exec_last && (op_q == OP_OV_SET || op_q == OP_OV_CLEAR) |=>
        stat_q[FLG_V] == ($past(op_q) == OP_OV_SET) && ((stat_q ^ $past(stat_q)) & 8'hF7) == 8'h00;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow op wrong");

  property p_signed;
    @(posedge hclk) disable iff (!hresetn)
      exec_last && (op_q == OP_SF_SET || op_q == OP_SF_CLEAR) |=>
        stat_q[FLG_S] == ($past(op_q) == OP_SF_SET) && ((stat_q ^ $past(stat_q)) & 8'hEF) == 8'h00;
  endproperty
  a_signed: assert property (p_signed) else $error("signed flag op wrong");

  property p_pm_load;
    @(posedge hclk) disable iff (!hresetn)
      issue_fire && iss.op == OP_PM_LOAD |=> (busy && !exec_last)[*2] ##1 exec_last ##1
        !busy && stat_q == $past(stat_q, 3);
  endproperty
  a_pm_load: assert property (p_pm_load) else $error("program load timing wrong");

  property p_ind_xfer;
    @(posedge hclk) disable iff (!hresetn)
      issue_fire && (iss.op == OP_IND_LOAD || iss.op == OP_IND_STORE) |=> !exec_last ##1 exec_last ##1 !busy;
  endproperty
  a_ind_xfer: assert property (p_ind_xfer) else $error("indirect transfer timing wrong");

  property p_one_cycle;
    @(posedge hclk) disable iff (!hresetn)
      issue_fire && (iss.op == OP_MOVE || iss.op == OP_LOAD_IMM || iss.op == OP_PORT_IN || iss.op == OP_PORT_OUT)
        |=> exec_last ##1 !busy && stat_q == $past(stat_q);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("single cycle transfer wrong");

endmodule

// ---- sim/bfx_exec_bench.sv ----
// self-checking bench for the bit and flag execution unit
// assumes bfx_pkg and bfx_exec are compiled first; the bench is the bus master and the external spaces
module bfx_exec_bench
  import bfx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals and design
  // ****************************************
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  bfx_ext_t    ext_req;
  logic [7:0]  ext_rdata;
  int          fails = 0;
  int          check_count = 0;
  int          step = 5;
  logic        iss_pend = 1'b0;
  bfx_ext_t    trace [1:4];

  bfx_exec dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .ext_req   (ext_req),
    .ext_rdata (ext_rdata)
  );

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // 250 MHz core clock
  always #2ns hclk = ~hclk;

  // content of the external spaces; inverted when not strobed so a stale capture shows
  function automatic logic [7:0] space_val(input bfx_space_t sp, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A ^ {6'h0, sp};
  endfunction

  assign ext_rdata = ext_req.re ? space_val(ext_req.space, ext_req.addr) : ~space_val(ext_req.space, ext_req.addr);

  // record the external strobes of the four cycles after each issue edge
  always @(posedge hclk) begin
    if (step >= 1 && step <= 4) begin
      trace[step] = ext_req;
    end
    step = iss_pend ? 1 : (step < 5 ? step + 1 : 5);
    iss_pend = hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFS_ISSUE;
  end

  // ****************************************
  // bus, compare and verdict
  // ****************************************
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("okay response", {31'h0, hresp}, 32'h0);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks made %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // expected behaviour
  // ****************************************
  function automatic int cycles(input logic [4:0] op);
    case (op)
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_IND_LOAD, OP_IND_STORE: return 2;
      OP_PM_LOAD: return 3;
      default: return 1;
    endcase
  endfunction

  // result (rv low where none is defined) and new status
  function automatic void predict(input logic [4:0] op, input logic [7:0] rd, src, s, input logic [2:0] b,
                                  input logic [15:0] z, input logic [5:0] a, output logic [7:0] r, ns,
                                  output logic rv);
    r = rd;
    ns = s;
    rv = 1'b1;
    case (op)
      OP_BIT_TO_TFLAG: begin
        ns[FLG_T] = src[b];
        rv = 1'b0;
      end
      OP_TFLAG_TO_BIT: r[b] = s[FLG_T];
      OP_ROT_LEFT, OP_ROT_RIGHT: begin
        r = (op == OP_ROT_LEFT) ? {rd[6:0], s[FLG_C]} : {s[FLG_C], rd[7:1]};
        ns[FLG_C] = (op == OP_ROT_LEFT) ? rd[7] : rd[0];
        ns[FLG_Z] = (r == 8'h00);
        ns[FLG_N] = r[7];
        ns[FLG_V] = r[7] ^ ns[FLG_C];
      end
      OP_HC_SET: ns[FLG_H] = 1'b1;
      OP_HC_CLEAR: ns[FLG_H] = 1'b0;
      OP_OV_SET: ns[FLG_V] = 1'b1;
      OP_OV_CLEAR: ns[FLG_V] = 1'b0;
      OP_SF_SET: ns[FLG_S] = 1'b1;
      OP_SF_CLEAR: ns[FLG_S] = 1'b0;
      OP_IND_LOAD: r = space_val(SP_DATA, z);
      OP_PM_LOAD: r = space_val(SP_PROG, z);
      OP_PORT_IN: r = space_val(SP_IO, {10'h0, a});
      OP_MOVE, OP_LOAD_IMM: r = src;
      default: rv = 1'b0;
    endcase
  endfunction

  // external request expected in cycle k after the issue edge
  function automatic bfx_ext_t walk(input logic [4:0] op, input int k, input logic [7:0] rd,
                                    input logic [2:0] b, input logic [15:0] z, input logic [5:0] a);
    bfx_ext_t    e;
    logic [15:0] io;
    logic [7:0]  v;
    e = '0;
    io = {10'h0, a};
    v = space_val(SP_IO, io);
    case (op)
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
        if (k == 1) e = '{1'b1, 1'b0, SP_IO, io, 8'h00};
        if (k == 2) e = '{1'b0, 1'b1, SP_IO, io, op == OP_IO_BIT_SET ? v | (8'h01 << b) : v & ~(8'h01 << b)};
      end
      OP_PORT_IN: if (k == 1) e = '{1'b1, 1'b0, SP_IO, io, 8'h00};
      OP_PORT_OUT: if (k == 1) e = '{1'b0, 1'b1, SP_IO, io, rd};
      OP_IND_LOAD: if (k <= 2) e = '{1'b1, 1'b0, SP_DATA, z, 8'h00};
      OP_IND_STORE: if (k == 2) e = '{1'b0, 1'b1, SP_DATA, z, rd};
      OP_PM_LOAD: if (k <= 3) e = '{1'b1, 1'b0, SP_PROG, z, 8'h00};
      default: ;
    endcase
    return e;
  endfunction

  // one operation: load operands and status, issue, then check timing, result, status and strobes
  task automatic run_op(input logic [4:0] op, input int it);
    logic [7:0]  rd, src, s, r, ns;
    logic [15:0] z;
    logic [5:0]  a;
    logic [2:0]  b;
    logic        rv;
    logic [31:0] got;
    bfx_ext_t    e;
    int          n;
    rd = $urandom;
    src = $urandom;
    s = $urandom;
    z = $urandom;
    a = $urandom;
    b = $urandom;
    // corners: carry out of an all-but-one-zero byte, and every flag set
    if (it == 0) begin
      rd = (op == OP_ROT_RIGHT) ? 8'h01 : 8'h80;
      s = 8'h00;
      b = 3'h0;
    end
    if (it == 1) begin
      s = 8'hFF;
      b = 3'h7;
    end
    // which operand feeds the T copy is open, so both carry the same byte
    if (op == OP_BIT_TO_TFLAG) rd = src;
    n = cycles(op);
    predict(op, rd, src, s, b, z, a, r, ns, rv);
    bus(1'b1, OFS_OPERAND, {z, src, rd}, got);
    bus(1'b1, OFS_STATUS, {24'h0, s}, got);
    bus(1'b1, OFS_ISSUE, {10'h0, a, 5'h0, b, 3'h0, op}, got);
    bus(1'b0, OFS_RESULT, 32'h0, got);
    check("early busy", {31'h0, got[RES_BUSY]}, {31'h0, n > 1});
    if (n == 1 && rv) check("early result", {24'h0, got[7:0]}, {24'h0, r});
    bus(1'b0, OFS_RESULT, 32'h0, got);
    check("busy", {31'h0, got[RES_BUSY]}, 32'h0);
    if (rv) check("result", {24'h0, got[7:0]}, {24'h0, r});
    bus(1'b0, OFS_STATUS, 32'h0, got);
    check("status", got, {24'h0, ns});
    for (int k = 1; k <= 4; k++) begin
      e = walk(op, k, rd, b, z, a);
      check("ext strobes", {30'h0, trace[k].re, trace[k].we}, {30'h0, e.re, e.we});
      if (e.re || e.we) check("ext place", {14'h0, trace[k].space, trace[k].addr}, {14'h0, e.space, e.addr});
      if (e.we) check("ext wdata", {24'h0, trace[k].wdata}, {24'h0, e.wdata});
    end
  endtask

  // ****************************************
  // sequence and watchdog
  // ****************************************
  // whole run is about 1540 cycles, so this limit only trips on a hang
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    summarize();
  end

  // reset, reset values and refused places, then every defined code and 5'h1F several times
  initial begin
    logic [31:0] got;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    void'($urandom(82956));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_OPERAND, 32'h0, got);
    check("operand after reset", got, OPND_RST);
    bus(1'b0, OFS_STATUS, 32'h0, got);
    check("status after reset", got, {24'h0, STAT_RST});
    bus(1'b0, OFS_RESULT, 32'h0, got);
    check("result after reset", got, {24'h0, RESULT_RST});
    bus(1'b1, 8'h10, 32'hFFFF_FFFF, got);
    bus(1'b0, 8'h10, 32'h0, got);
    check("unmapped read", got, 32'h0);
    bus(1'b0, OFS_ISSUE, 32'h0, got);
    check("write-only read", got, 32'h0);
    for (int o = 0; o < 21; o++) begin
      for (int it = 0; it < 4; it++) begin
        run_op(o == 20 ? 5'h1F : 5'(o), it);
      end
    end
    summarize();
  end
endmodule
